// file: pkg/asl_defs.vh
// Constants for the advanced sequence table loader.
// Assumes inclusion by bare name from hw/ sources.
`ifndef ASL_DEFS_VH
`define ASL_DEFS_VH

`define ASL_CHR_HASH     8'h23
`define ASL_CHR_ZERO     8'h30
`define ASL_CHR_NINE     8'h39
`define ASL_CHR_ONE      8'h31
`define ASL_ENTRY_BYTES  3'h7
`define ASL_NCH          2'h3
`define ASL_DEPTH        16
`define ASL_IDX_W        4
`define ASL_LEN_W        16
`define ASL_LEN_DEF      16'h0001
`define ASL_LEN_MAX      16'h03e8
`define ASL_STEP_MAX     16'h8000
`define ASL_LOOP_LO      31:0
`define ASL_SEQ_LO       47:32
`define ASL_JMP_LO       63:48
`define ASL_JMP_BIT      48
`define ASL_MODE_AUTO    2'h0
`define ASL_MODE_ONCE    2'h1
`define ASL_MODE_STEP    2'h2

`endif

// file: hw/asl_skid_buf.v
// Two-entry buffer between the byte parser and the table writer.
// Assumes one clock; source holds data while inReady is low.
`timescale 1ns/1ps

module asl_skid_buf (
	clock,
	rst,
	inValid,
	inData,
	inReady,
	outValid,
	outData,
	outReady
);
	input  wire        clock;
	input  wire        rst;
	input  wire        inValid;
	input  wire [79:0] inData;
	output wire        inReady;
	output wire        outValid;
	output wire [79:0] outData;
	input  wire        outReady;

	reg [79:0] mem_ff [0:1];
	reg        wrPtr_ff;
	reg        rdPtr_ff;
	reg [1:0]  cnt_ff;

	wire doWr = inValid && (cnt_ff != 2'h2);
	wire doRd = (cnt_ff != 2'h0) && outReady;

	assign inReady  = (cnt_ff != 2'h2);
	assign outValid = (cnt_ff != 2'h0);
	assign outData  = mem_ff[rdPtr_ff];

	always @(posedge clock) begin
		if (rst) begin
			wrPtr_ff <= 1'b0;
			rdPtr_ff <= 1'b0;
			cnt_ff   <= 2'h0;
		end else begin
			if (doWr) begin
				mem_ff[wrPtr_ff] <= inData;
				wrPtr_ff         <= ~wrPtr_ff;
			end
			if (doRd)
				rdPtr_ff <= ~rdPtr_ff;
			if (doWr && !doRd)
				cnt_ff <= cnt_ff + 2'h1;
			else if (doRd && !doWr)
				cnt_ff <= cnt_ff - 2'h1;
		end
	end
endmodule

// file: hw/asl_table_loader.v
// Advanced sequence table loader: binary block parser, step define, clear, length and a step walker.
// Assumes a command decoder upstream hands bytes and decoded commands on the device clock.
//
// Functional notes
// R1: Hash byte opens the binary block
// R2: Digit count then exactly that many length digits
// R3: Host sends byte count multiple of eight
// R4: Each step built from one 64-bit entry
// R5: CR and LF inside block are data
// R6: Entry splits loops, sequence number, jump flag
// R7: Separate table per channel, selected channel written; clear wipes the entries of all four channels
// R8: Host sends three to 32768 steps; tables here hold 16 steps per channel
// R9: No content validation, no error response
// R10: Steps numbered in arrival order from one
// R11: Binary download sets length to step count
// R12: Host defines steps ascending, no gaps
// R13: Host defines at least three steps
// R14: Step plays its stored sequence number
// R15: Step repeats for its loop count
// R16: Jump flag one waits for event
// R17: Step define adjusts length automatically
// R18: Define while running restarts the sequence
// R19: Clear command resets whole table
// R20: Length one to 1000, default one, readable
// R21: Auto, once and event-stepped advance modes
// R22: Stepped mode ignores jump, still loops
// R23: Bytes LSB first, commit after eight
`timescale 1ns/1ps
`include "asl_defs.vh"

module asl_table_loader (
	clock,
	rst,
	byteValid,
	byteData,
	byteEoi,
	byteReady,
	chanSel,
	defStrobe,
	defStep,
	defSeq,
	defLoops,
	defJump,
	clearCmd,
	lenWrite,
	lenValue,
	advMode,
	onceCount,
	runEnable,
	eventIn,
	tableLen,
	playSeq,
	playStep,
	playActive,
	loadBusy
);
	input  wire        clock;
	input  wire        rst;
	input  wire        byteValid;
	input  wire [7:0]  byteData;
	input  wire        byteEoi;
	output reg         byteReady;
	input  wire [1:0]  chanSel;
	input  wire        defStrobe;
	input  wire [15:0] defStep;
	input  wire [15:0] defSeq;
	input  wire [31:0] defLoops;
	input  wire        defJump;
	input  wire        clearCmd;
	input  wire        lenWrite;
	input  wire [15:0] lenValue;
	input  wire [1:0]  advMode;
	input  wire [19:0] onceCount;
	input  wire        runEnable;
	input  wire        eventIn;
	output reg  [15:0] tableLen;
	output reg  [15:0] playSeq;
	output reg  [15:0] playStep;
	output reg         playActive;
	output reg         loadBusy;

	// =====================================================
	// Parser states
	localparam S_IDLE  = 4'b0001;
	localparam S_NDIG  = 4'b0010;
	localparam S_COUNT = 4'b0100;
	localparam S_DATA  = 4'b1000;

	reg [3:0]  state_ff;
	reg [3:0]  digLeft_ff;
	reg [31:0] byteCnt_ff;
	reg [63:0] entry_ff;
	reg [2:0]  bytePos_ff;
	reg [15:0] stepIdx_ff;
	reg [1:0]  loadCh_ff;
	reg        evS1_ff;
	reg        evS2_ff;
	reg        evOld_ff;

	// Buffer carries {channel, step index, entry}
	wire        bufInReady;
	wire        bufOutValid;
	wire [79:0] bufOutData;
	reg         pushValid;
	reg  [79:0] pushData;
	// Clear wins over a table write, so the buffer holds the word meanwhile
	wire        tblReady = !clearCmd;

	wire takeByte = byteValid && byteReady;
	wire isDigit  = (byteData >= `ASL_CHR_ZERO) && (byteData <= `ASL_CHR_NINE);
	wire [3:0] digVal = byteData[3:0];

	asl_skid_buf u_buf (
		.clock    (clock),
		.rst      (rst),
		.inValid  (pushValid),
		.inData   (pushData),
		.inReady  (bufInReady),
		.outValid (bufOutValid),
		.outData  (bufOutData),
		.outReady (tblReady)
	);

	// =====================================================
	// Block header and data parser
	always @(posedge clock) begin
		if (rst) begin
			state_ff   <= S_IDLE;
			digLeft_ff <= 4'h0;
			byteCnt_ff <= 32'h0;
			entry_ff   <= 64'h0;
			bytePos_ff <= 3'h0;
			stepIdx_ff <= 16'h0;
			loadCh_ff  <= 2'h0;
			byteReady  <= 1'b0;
			pushValid  <= 1'b0;
			pushData   <= 80'h0;
			loadBusy   <= 1'b0;
		end else begin
			// Stall bytes while a word waits for buffer room
			byteReady <= !(pushValid && !bufInReady) &&
			             !(state_ff == S_DATA && bytePos_ff == `ASL_ENTRY_BYTES && takeByte);
			if (pushValid && bufInReady)
				pushValid <= 1'b0;
			if (takeByte) begin
				case (state_ff)
				S_IDLE: begin
					if (byteData == `ASL_CHR_HASH) begin // R1
						state_ff  <= S_NDIG;
						loadBusy  <= 1'b1;
						loadCh_ff <= chanSel; // R7
					end
				end
				S_NDIG: begin
					digLeft_ff <= digVal; // R2
					byteCnt_ff <= 32'h0;
					state_ff   <= (isDigit && digVal != 4'h0) ? S_COUNT : S_IDLE;
					loadBusy   <= isDigit && (digVal != 4'h0);
				end
				S_COUNT: begin
					byteCnt_ff <= byteCnt_ff * 32'd10 + {28'h0, digVal}; // R2
					digLeft_ff <= digLeft_ff - 4'h1;
					if (digLeft_ff == 4'h1) begin
						state_ff   <= S_DATA;
						bytePos_ff <= 3'h0;
						stepIdx_ff <= 16'h0;
					end
				end
				S_DATA: begin
					// Any byte value counts as data, including 0d and 0a
					entry_ff[bytePos_ff*8 +: 8] <= byteData; // R5 R23
					bytePos_ff <= bytePos_ff + 3'h1;
					byteCnt_ff <= byteCnt_ff - 32'h1;
					if (bytePos_ff == `ASL_ENTRY_BYTES) begin // R4 R23
						pushValid  <= 1'b1;
						pushData   <= {loadCh_ff, stepIdx_ff[`ASL_IDX_W-1:0] , 10'h0, byteData, entry_ff[55:0]}; // R10
						stepIdx_ff <= stepIdx_ff + 16'h1;
					end
					// A short or odd count just leaves a mis-partitioned table
					if (byteCnt_ff == 32'h1 || byteEoi) begin // R9
						state_ff <= S_IDLE;
						loadBusy <= 1'b0;
					end
				end
				default: begin
					state_ff <= S_IDLE;
					loadBusy <= 1'b0;
				end
				endcase
			end
		end
	end

	// =====================================================
	// Per-channel tables (depth limited to storage here)
	reg [31:0] loops_ff [0:63];
	reg [15:0] seq_ff   [0:63];
	reg        jump_ff  [0:63];
	reg [15:0] len_ff   [0:3];
	reg        restart_ff;
	integer    i;

	wire [1:0]  wCh   = bufOutData[79:78];
	wire [3:0]  wIdx  = bufOutData[77:74];
	wire [63:0] wEnt  = bufOutData[63:0];
	wire [3:0]  dIdx  = defStep[3:0] - 4'h1;

	always @(posedge clock) begin
		if (rst) begin
			// Empty entries keep playSeq defined straight after reset
			for (i = 0; i < 64; i = i + 1) begin
				loops_ff[i] <= 32'h0;
				seq_ff[i]   <= 16'h0;
				jump_ff[i]  <= 1'b0;
			end
			for (i = 0; i < 4; i = i + 1)
				len_ff[i] <= `ASL_LEN_DEF;
			restart_ff <= 1'b0;
		end else begin
			restart_ff <= 1'b0;
			if (clearCmd) begin // R19
				for (i = 0; i < 64; i = i + 1) begin
					loops_ff[i] <= 32'h0;
					seq_ff[i]   <= 16'h0;
					jump_ff[i]  <= 1'b0;
				end
				len_ff[chanSel] <= `ASL_LEN_DEF;
				restart_ff      <= 1'b1;
			end else if (bufOutValid) begin
				loops_ff[{wCh, wIdx}] <= wEnt[`ASL_LOOP_LO]; // R6
				seq_ff[{wCh, wIdx}]   <= wEnt[`ASL_SEQ_LO];
				jump_ff[{wCh, wIdx}]  <= wEnt[`ASL_JMP_BIT]; // R16
				len_ff[wCh]           <= {12'h0, wIdx} + 16'h1; // R11
				restart_ff            <= 1'b1;
			end else if (defStrobe) begin
				loops_ff[{chanSel, dIdx}] <= defLoops;
				seq_ff[{chanSel, dIdx}]   <= defSeq;
				jump_ff[{chanSel, dIdx}]  <= defJump;
				len_ff[chanSel]           <= defStep; // R17
				restart_ff                <= 1'b1; // R18
			end else if (lenWrite && lenValue != 16'h0 && lenValue <= `ASL_LEN_MAX) begin
				len_ff[chanSel] <= lenValue; // R20
			end
		end
	end

	// =====================================================
	// Step walker on the selected channel
	reg [31:0] loopCnt_ff;
	reg [19:0] passCnt_ff;
	reg        done_ff;
	reg        armed_ff;
	wire [5:0] curAddr = {chanSel, playStep[3:0]};
	wire       evPulse = evS2_ff && !evOld_ff;
	wire       armedNow = armed_ff || evPulse;
	wire       stepMode = (advMode == `ASL_MODE_STEP);
	// An event is latched until the step advances; a second one meanwhile is lost
	wire       canLoop  = !stepMode || armedNow; // R22
	wire       canAdv   = stepMode ? armedNow : (!jump_ff[curAddr] || armedNow); // R16 R22
	wire       lastStep = (playStep + 16'h1 >= len_ff[chanSel]);
	wire       loopDone = (loopCnt_ff + 32'h1 >= loops_ff[curAddr]);

	always @(posedge clock) begin
		if (rst) begin
			evS1_ff    <= 1'b0;
			evS2_ff    <= 1'b0;
			evOld_ff   <= 1'b0;
			playStep   <= 16'h0;
			loopCnt_ff <= 32'h0;
			passCnt_ff <= 20'h0;
			done_ff    <= 1'b0;
			armed_ff   <= 1'b0;
			playActive <= 1'b0;
			playSeq    <= 16'h0;
			tableLen   <= `ASL_LEN_DEF;
		end else begin
			evS1_ff  <= eventIn;
			evS2_ff  <= evS1_ff;
			evOld_ff <= evS2_ff;
			tableLen <= len_ff[chanSel]; // R20
			playSeq  <= seq_ff[curAddr]; // R14
			playActive <= runEnable && !done_ff;
			if (!runEnable || restart_ff) begin // R18
				playStep   <= 16'h0;
				loopCnt_ff <= 32'h0;
				passCnt_ff <= 20'h0;
				done_ff    <= 1'b0;
				armed_ff   <= 1'b0;
			end else if (!done_ff) begin
				if (evPulse)
					armed_ff <= 1'b1;
				if (canLoop) begin // R21 R22
					if (!loopDone) begin
						loopCnt_ff <= loopCnt_ff + 32'h1; // R15
					end else if (canAdv) begin // R16
						loopCnt_ff <= 32'h0;
						armed_ff   <= 1'b0;
						if (lastStep) begin
							playStep <= 16'h0;
							if (advMode == `ASL_MODE_ONCE) begin
								passCnt_ff <= passCnt_ff + 20'h1;
								if (passCnt_ff + 20'h1 >= onceCount)
									done_ff <= 1'b1;
							end
						end else begin
							playStep <= playStep + 16'h1; // R10
						end
					end
				end
			end
		end
	end
endmodule

// file: tb/asl_host_model.sv
// Host side: sends one definite-length table block.
// Assumes the bench fills ent before calling blk.
`timescale 1ns/1ps
module asl_host_model (
	input  wire       clock,
	input  wire       byteReady,
	output reg        byteValid,
	output reg  [7:0] byteData,
	output reg        byteEoi
);
	// ==========
	// Byte handshake
	reg [63:0] ent [0:7];
	initial begin
		byteValid = 1'b0;
		byteData = 8'h00;
		byteEoi = 1'b0;
	end
	task putb(input [7:0] b, input e);
		begin
			@(negedge clock);
			byteValid = 1'b1;
			byteData = b;
			byteEoi = e;
			@(posedge clock);
			while (byteReady !== 1'b1) @(posedge clock);
		end
	endtask
	task blk(input integer n);
		integer i;
		begin
			putb(8'h23, 1'b0);
			putb(8'h32, 1'b0);
			putb(8'(8'h30 + 8 * n / 10), 1'b0);
			putb(8'(8'h30 + 8 * n % 10), 1'b0);
			for (i = 0; i < 8 * n; i = i + 1)
				putb(ent[i / 8][8 * (i % 8) +: 8], i == 8 * n - 1);
			// Released bus shows the inverse so no stale byte looks valid
			@(negedge clock);
			byteValid = 1'b0;
			byteData = ~byteData;
			byteEoi = 1'b0;
		end
	endtask
endmodule

// file: tb/asl_table_loader_monitor.sv
// Port checker for the table loader.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module asl_table_loader_monitor (
	input wire        clock,
	input wire        rst,
	input wire        byteValid,
	input wire [7:0]  byteData,
	input wire        byteEoi,
	input wire        byteReady,
	input wire [1:0]  chanSel,
	input wire        defStrobe,
	input wire        clearCmd,
	input wire        lenWrite,
	input wire [15:0] lenValue,
	input wire [15:0] tableLen,
	input wire        playActive,
	input wire        loadBusy
);
	// ==========
	// Properties
	reg [15:0] lv_ff;
	always @(posedge clock) begin
		if (lenWrite) lv_ff <= lenValue;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire take = byteValid && byteReady;
	wire calm = !clearCmd && !defStrobe && !loadBusy;
	property p_rst; $fell(rst) |-> tableLen == 16'h0001 && !playActive && !loadBusy && !byteReady; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_rdy; $fell(rst) |=> byteReady; endproperty
	a_rdy: assert property (p_rdy) else $error("not ready after reset");
	property p_hash; take && byteData == 8'h23 && !loadBusy |=> loadBusy; endproperty
	a_hash: assert property (p_hash) else $error("block start missed");
	property p_skip; take && byteData != 8'h23 && !loadBusy |=> !loadBusy; endproperty
	a_skip: assert property (p_skip) else $error("stray byte opened block");
	property p_idle; !loadBusy && !byteValid |=> !loadBusy; endproperty
	a_idle: assert property (p_idle) else $error("busy without byte");
	property p_eoi; take && byteEoi && loadBusy |-> ##[1:3] !loadBusy; endproperty
	a_eoi: assert property (p_eoi) else $error("block not closed");
	property p_len; lenWrite && lenValue != 16'h0 && lenValue <= 16'h03e8 && calm |-> ##[1:2] tableLen == lv_ff; endproperty
	a_len: assert property (p_len) else $error("length not taken");
	property p_lbad; lenWrite && (lenValue == 16'h0 || lenValue > 16'h03e8) && calm |=> (!$stable(chanSel)) or (##1 $stable(tableLen)); endproperty
	a_lbad: assert property (p_lbad) else $error("bad length taken");
endmodule

// file: tb/tb_asl_table_loader.sv
// Self-checking bench for the table loader.
// Assumes the host model drives the byte port.
`timescale 1ns/1ps
module tb_asl_table_loader;
	reg         clock, rst, defStrobe, clearCmd, lenWrite, runEnable, eventIn;
	reg  [1:0]  chanSel, advMode;
	reg  [15:0] defStep, defSeq, lenValue;
	reg  [31:0] defLoops;
	reg         defJump;
	reg  [19:0] onceCount;
	wire        byteValid, byteEoi, byteReady, playActive, loadBusy;
	wire [7:0]  byteData;
	wire [15:0] tableLen, playSeq, playStep;
	integer     errors, check_count, i, k;
	integer     expLen [0:3];
	reg  [15:0] sq [0:2];
	integer     sqd [$], lpd [$];
	asl_table_loader dut_u (.clock, .rst, .byteValid, .byteData, .byteEoi, .byteReady, .chanSel,
		.defStrobe, .defStep, .defSeq, .defLoops, .defJump, .clearCmd, .lenWrite, .lenValue,
		.advMode, .onceCount, .runEnable, .eventIn, .tableLen, .playSeq, .playStep,
		.playActive, .loadBusy);
	asl_host_model host_u (.clock, .byteReady, .byteValid, .byteData, .byteEoi);
	// ==========
	// Helpers
	task chk(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task results;
		begin
			$display("errors=%0d checks=%0d", errors, check_count);
			if (errors == 0 && check_count > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(negedge clock);
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		#500000;
		errors = errors + 1;
		results;
	end
	// ==========
	// Tests
	initial begin
		{rst, defStrobe, clearCmd, lenWrite, runEnable, eventIn} = 6'h20;
		{chanSel, advMode, defStep, defSeq, lenValue} = 52'h0;
		{defLoops, defJump, onceCount} = 53'h1;
		errors = 0;
		check_count = 0;
		for (k = 0; k < 4; k = k + 1) expLen[k] = 1;
		k = $urandom(32'ha75d);
		chanSel = 2'h1;
		cyc(20);
		rst = 1'b0;
		cyc(2);
		for (i = 0; i < 3; i = i + 1) begin
			// First entry carries CR and LF bytes as data
			sq[i] = (i == 0) ? 16'h0a0d : 16'($urandom % 1000 + 1);
			host_u.ent[i] = {15'h0, 1'($urandom), sq[i], 32'h1};
		end
		host_u.putb(8'h0d, 1'b0);
		host_u.blk(3);
		expLen[1] = 3;
		cyc(10);
		chk(tableLen, expLen[1]);
		chanSel = 2'h0;
		cyc(3);
		chk(tableLen, expLen[0]);
		chanSel = 2'h1;
		advMode = 2'h2;
		runEnable = 1'b1;
		for (k = 0; k < 4; k = k + 1) begin
			cyc(20);
			chk(playSeq, sq[k % 3]);
			eventIn = 1'b1;
			cyc(4);
			eventIn = 1'b0;
		end
		runEnable = 1'b0;
		for (k = 0; k < 3; k = k + 1) begin
			advMode = 2'(k & 1);
			lenValue = (k == 0) ? 16'h0005 : (k == 1) ? 16'h0000 : 16'h03e9;
			lenWrite = 1'b1;
			cyc(1);
			lenWrite = 1'b0;
			cyc(4);
			chk(tableLen, 5);
		end
		chanSel = 2'h2;
		cyc(3);
		for (i = 1; i < 4; i = i + 1) begin
			defStep = 16'(i);
			defSeq = 16'($urandom % 1000 + 1);
			defLoops = $urandom % 4 + 1;
			defJump = (i == 2);
			sqd.push_back(defSeq);
			lpd.push_back(defLoops);
			defStrobe = 1'b1;
			cyc(1);
			defStrobe = 1'b0;
			cyc(6);
		end
		expLen[2] = 3;
		chk(tableLen, expLen[2]);
		// Once mode: step two dwells on its jump flag until an event
		advMode = 2'h1;
		runEnable = 1'b1;
		cyc(lpd[0] + lpd[1] + 4);
		chk(playStep, 1);
		chk(playSeq, sqd[1]);
		eventIn = 1'b1;
		cyc(4);
		eventIn = 1'b0;
		cyc(lpd[2] + 8);
		chk(playActive, 0);
		chk(playStep, 0);
		runEnable = 1'b0;
		clearCmd = 1'b1;
		cyc(1);
		clearCmd = 1'b0;
		cyc(6);
		expLen[2] = 1;
		chk(tableLen, expLen[2]);
		results;
	end
endmodule
bind asl_table_loader asl_table_loader_monitor mon_u (.clock, .rst, .byteValid, .byteData, .byteEoi,
	.byteReady, .chanSel, .defStrobe, .clearCmd, .lenWrite, .lenValue, .tableLen, .playActive, .loadBusy);
